/* File: include/crs_pkg.sv */
`default_nettype none
package crs_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 25;
   localparam int OUT_RELEASE_CLKS = 2;      // outputs quiet within two clocks of init
   localparam int CFG_W            = 8;      // sampled configuration width
   localparam int SAVE_CLKS        = 4;      // state save duration
   localparam int ACK_CLKS         = 1;      // acknowledge transaction length
   localparam int SYNC_STAGES      = 2;

   // ----------------------------------------------------------------
   // power / mode states, gray along the usual path except handler exit to run
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CRS_INIT  = 3'h0,
      CRS_RUN   = 3'h1,
      CRS_HALT  = 3'h3,
      CRS_SLEEP = 3'h2,
      CRS_SAVE  = 3'h5,
      CRS_ACK   = 3'h7,
      CRS_MGMT  = 3'h6
   } crs_state_t;
endpackage : crs_pkg
`default_nettype wire

/* File: core/crs_sync.sv */
`default_nettype none
module crs_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_d;

   // two-stage synchroniser, reset to all ones
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule : crs_sync
`default_nettype wire

/* File: core/crs_ctrl.sv */
// Summary of operation
// (RL1) hard init returns to known state, invalidates caches without write-back.
// (RL2) system holds hard init at least 1 ms after power-on.
// (RL3) outputs deasserted no later than two clocks after init seen.
// (RL4) system never holds init above 10 ms while supplies are stable.
// (RL5) configuration pins latched on init release edge.
// (RL6) management interrupt during init release tristates all outputs.
// (RL7) management interrupt input synchronised internally.
// (RL8) accepted management interrupt saves state then enters handler mode.
// (RL9) acknowledge transaction issued, then handler fetch starts.
// (RL10) sleep request in clock-halt state enters sleep.
// (RL11) sleep gates all unit clocks, only the pll keeps running.
// (RL12) sleep ignores snoops and interrupts.
// (RL13) sleep responds only to init, sleep release, bus clock loss; code leaves sleep on init or sleep release only, bus clock loss has no effect.
// (RL14) sleep release re-enables bus and core clocks, back to halt; code re-enables bus and apic clocks, core clock stays off in halt.
// (RL15) clock-halt request enters halt; bus and interrupt units keep running.
// (RL16) each supplies-stable rise is followed by a 1 to 10 ms init.
// (RL17) hard init overrides sleep, halt and management entry.
`default_nettype none
module crs_ctrl #(
   parameter int CFG_W = crs_pkg::CFG_W
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // system control pins, asynchronous
   input  wire logic             hard_init_n,
   input  wire logic             supplies_stable,
   input  wire logic             sleep_request_n,
   input  wire logic             clock_halt_request_n,
   input  wire logic             mgmt_interrupt_n,
   input  wire logic             bclk_present,
   // configuration bus levels
   input  wire logic [CFG_W-1:0] cfg_pins,
   // core side
   input  wire logic             core_bus_req,
   input  wire logic             snoop_req,
   input  wire logic             intr_req,
   input  wire logic             mgmt_exit,
   // outputs to core and pins
   output logic                  bus_out_active,
   output logic                  bus_out_oe_n,
   output logic                  cache_invalidate,
   output logic                  cache_writeback_en,
   output logic [CFG_W-1:0]      cfg_options,
   output logic                  cfg_valid,
   output logic                  core_clk_en,
   output logic                  bus_clk_en,
   output logic                  apic_clk_en,
   output logic                  pll_en,
   output logic                  snoop_accept,
   output logic                  intr_accept,
   output logic                  state_save,
   output logic                  mgmt_ack_txn,
   output logic                  protected_handler_mode,
   output logic                  handler_fetch,
   output logic                  sleeping
);
   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] syn;
   logic             init_s;
   logic             pg_s;
   logic             slp_s;
   logic             halt_s;
   logic             mgmt_s;
   logic             bclk_s;

   // init bit inverted so reset reads as init active, no false release edge
   assign raw_in = {bclk_present, mgmt_interrupt_n, clock_halt_request_n,
                    sleep_request_n, ~supplies_stable, ~hard_init_n};

   // all control pins pass two flops before use
   crs_sync #(.WIDTH(NSYNC)) u_sync ( // RL7
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (raw_in),
      .sync_out (syn)
   );

   // configuration levels are pins too: two flops before the latch
   logic [CFG_W-1:0] cfg_s;

   crs_sync #(.WIDTH(CFG_W)) u_cfg_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (cfg_pins),
      .sync_out (cfg_s)
   );

   assign init_s = syn[0];
   assign pg_s   = ~syn[1];
   assign slp_s  = ~syn[2];
   assign halt_s = ~syn[3];
   assign mgmt_s = ~syn[4];
   assign bclk_s = syn[5];

   // ----------------------------------------------------------------
   // state and counters
   // ----------------------------------------------------------------
   crs_pkg::crs_state_t   state_q;
   crs_pkg::crs_state_t   state_d;
   logic [2:0]            cnt_q;
   logic [2:0]            cnt_d;
   logic                  init_prev_q;
   logic                  init_prev_d;
   logic                  tri_q;
   logic                  tri_d;
   logic [CFG_W-1:0]      cfg_q;
   logic [CFG_W-1:0]      cfg_d;
   logic                  cfg_v_q;
   logic                  cfg_v_d;
   logic                  mgmt_pend_q;
   logic                  mgmt_pend_d;
   logic                  mgmt_prev_q;
   logic                  mgmt_prev_d;
   logic                  rel_edge;

   localparam logic [2:0] SAVE_LAST = 3'(crs_pkg::SAVE_CLKS - 1);
   localparam logic [2:0] ACK_LAST  = 3'(crs_pkg::ACK_CLKS - 1);

   // init release edge
   assign rel_edge = init_prev_q & ~init_s;

   // next-state logic
   always_comb begin
      state_d     = state_q;
      cnt_d       = cnt_q;
      init_prev_d = init_s;
      tri_d       = tri_q;
      cfg_d       = cfg_q;
      cfg_v_d     = cfg_v_q;
      mgmt_prev_d = mgmt_s;
      mgmt_pend_d = mgmt_pend_q;
      // falling edge of the interrupt request is latched until taken, or until init, init release or sleep clears it
      if (mgmt_s & ~mgmt_prev_q) begin
         mgmt_pend_d = 1'b1;
      end
      if (init_s) begin
         state_d     = crs_pkg::CRS_INIT; // RL17
         cnt_d       = '0;
         tri_d       = 1'b0;
         cfg_v_d     = 1'b0;
         mgmt_pend_d = 1'b0;
      end else if (rel_edge) begin
         cfg_d       = cfg_s; // RL5
         cfg_v_d     = 1'b1;
         tri_d       = mgmt_s; // RL6
         mgmt_pend_d = 1'b0;
         state_d     = crs_pkg::CRS_RUN;
      end else begin
         case (state_q)
            crs_pkg::CRS_INIT: begin
               state_d = crs_pkg::CRS_RUN;
            end
            crs_pkg::CRS_RUN: begin
               if (mgmt_pend_q) begin
                  state_d     = crs_pkg::CRS_SAVE; // RL8
                  mgmt_pend_d = 1'b0;
                  cnt_d       = '0;
               end else if (halt_s) begin
                  state_d = crs_pkg::CRS_HALT; // RL15
               end
            end
            crs_pkg::CRS_HALT: begin
               if (slp_s) begin
                  state_d = crs_pkg::CRS_SLEEP; // RL10
               end else if (!halt_s) begin
                  state_d = crs_pkg::CRS_RUN;
               end
            end
            crs_pkg::CRS_SLEEP: begin
               // only sleep release is seen here; init handled above
               mgmt_pend_d = 1'b0; // RL12
               if (!slp_s) begin
                  state_d = crs_pkg::CRS_HALT; // RL14
               end
            end
            crs_pkg::CRS_SAVE: begin
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == SAVE_LAST) begin
                  state_d = crs_pkg::CRS_ACK; // RL8
                  cnt_d   = '0;
               end
            end
            crs_pkg::CRS_ACK: begin
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == ACK_LAST) begin
                  state_d = crs_pkg::CRS_MGMT; // RL9
                  cnt_d   = '0;
               end
            end
            crs_pkg::CRS_MGMT: begin
               if (mgmt_exit) begin
                  state_d = crs_pkg::CRS_RUN;
               end
            end
            default: begin
               state_d = crs_pkg::CRS_INIT;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q     <= crs_pkg::CRS_INIT;
         cnt_q       <= '0;
         init_prev_q <= 1'b1;
         tri_q       <= 1'b0;
         cfg_q       <= '0;
         cfg_v_q     <= 1'b0;
         mgmt_pend_q <= 1'b0;
         mgmt_prev_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         init_prev_q <= init_prev_d;
         tri_q       <= tri_d;
         cfg_q       <= cfg_d;
         cfg_v_q     <= cfg_v_d;
         mgmt_pend_q <= mgmt_pend_d;
         mgmt_prev_q <= mgmt_prev_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic in_init;
   logic in_sleep;
   logic in_halt;
   logic bus_d;
   logic bus_q;

   assign in_init  = (state_q == crs_pkg::CRS_INIT);
   assign in_sleep = (state_q == crs_pkg::CRS_SLEEP);
   assign in_halt  = (state_q == crs_pkg::CRS_HALT);

   // bus drive: quiet while init is seen (sync delay plus this flop)
   always_comb begin
      bus_d = core_bus_req & ~init_s & ~in_init & ~in_sleep & ~tri_q; // RL3
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_q <= 1'b0;
      end else begin
         bus_q <= bus_d;
      end
   end

   assign bus_out_active     = bus_q;
   assign bus_out_oe_n       = tri_q; // RL6
   assign cache_invalidate   = in_init; // RL1
   assign cache_writeback_en = ~in_init; // RL1
   assign cfg_options        = cfg_q;
   assign cfg_valid          = cfg_v_q;
   assign pll_en             = 1'b1; // RL11
   assign core_clk_en        = ~in_sleep & ~in_halt; // RL11
   assign bus_clk_en         = ~in_sleep & bclk_s; // RL15
   assign apic_clk_en        = ~in_sleep; // RL15
   assign snoop_accept       = snoop_req & ~in_sleep & ~in_init; // RL12
   assign intr_accept        = intr_req & ~in_sleep & ~in_init; // RL13
   assign state_save         = (state_q == crs_pkg::CRS_SAVE);
   assign mgmt_ack_txn       = (state_q == crs_pkg::CRS_ACK); // RL9
   assign protected_handler_mode = (state_q == crs_pkg::CRS_MGMT) | mgmt_ack_txn;
   assign handler_fetch      = (state_q == crs_pkg::CRS_MGMT); // RL9
   assign sleeping           = in_sleep;

   // unused stable level kept for status only
   logic pg_unused;
   assign pg_unused = pg_s;
endmodule : crs_ctrl
`default_nettype wire

/* File: testbench/crs_ctrl_assertions.sv */
`default_nettype none
module crs_ctrl_assertions #(
   parameter int CFG_W = 8
) (
   // clock and reset
   input wire logic             ref_clk,
   input wire logic             rst,
   // pins
   input wire logic             hard_init_n,
   input wire logic             sleep_request_n,
   // outputs watched
   input wire logic [CFG_W-1:0] cfg_options,
   input wire logic             cfg_valid,
   input wire logic             bus_out_active,
   input wire logic             bus_out_oe_n,
   input wire logic             cache_invalidate,
   input wire logic             cache_writeback_en,
   input wire logic             core_clk_en,
   input wire logic             bus_clk_en,
   input wire logic             apic_clk_en,
   input wire logic             pll_en,
   input wire logic             snoop_accept,
   input wire logic             intr_accept,
   input wire logic             state_save,
   input wire logic             mgmt_ack_txn,
   input wire logic             protected_handler_mode,
   input wire logic             sleeping
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   bus_release_a: assert property ($fell(hard_init_n) |-> ##[0:3] !bus_out_active)
      else $error("bus not released after init");
   cache_drop_a: assert property (cache_invalidate |-> !cache_writeback_en
      && !bus_out_active && !cfg_valid) else $error("write-back or activity during invalidate");
   init_wins_a: assert property (!hard_init_n [*4] |-> cache_invalidate && !sleeping)
      else $error("init did not override mode");
   cfg_hold_a: assert property (cfg_valid && $past(cfg_valid) && !cache_invalidate
      && !$past(cache_invalidate) |-> $stable(cfg_options)) else $error("config changed");
   sleep_deaf_a: assert property (sleeping |-> !snoop_accept && !intr_accept)
      else $error("request accepted in sleep");
   sleep_gate_a: assert property (sleeping |-> !core_clk_en && !bus_clk_en && !apic_clk_en
      && pll_en) else $error("clocks running in sleep");
   sleep_entry_a: assert property ($rose(sleeping) |-> !$past(core_clk_en)
      && $past(bus_clk_en)) else $error("sleep entered outside halt");
   sleep_exit_a: assert property (sleeping && $rose(sleep_request_n) && hard_init_n
      |-> ##[1:4] !sleeping && bus_clk_en && !core_clk_en) else $error("no return to halt");
   mgmt_order_a: assert property ($rose(state_save) |-> state_save [*4] ##1 mgmt_ack_txn
      ##1 protected_handler_mode) else $error("management entry order");
   tri_release_a: assert property ($rose(bus_out_oe_n) |-> $past(cache_invalidate))
      else $error("tristate outside init release");

   // main scenarios reached
   cover property (sleeping);
   cover property ($rose(mgmt_ack_txn));
   cover property ($rose(bus_out_oe_n));
endmodule : crs_ctrl_assertions

bind crs_ctrl crs_ctrl_assertions #(.CFG_W(CFG_W)) u_chk (
   .ref_clk, .rst, .hard_init_n, .sleep_request_n, .cfg_options, .cfg_valid, .bus_out_active,
   .bus_out_oe_n, .cache_invalidate, .cache_writeback_en, .core_clk_en, .bus_clk_en,
   .apic_clk_en, .pll_en, .snoop_accept, .intr_accept, .state_save, .mgmt_ack_txn,
   .protected_handler_mode, .sleeping
);
`default_nettype wire

/* File: testbench/crs_sys_model.sv */
`default_nettype none
module crs_sys_model #(
   parameter int INIT_CLKS = 40
) (
   // clock
   input  wire logic ref_clk,
   // control pins toward the device
   output var logic  hard_init_n = 1'b0,
   output var logic  supplies_stable = 1'b0,
   output var logic  sleep_request_n = 1'b1,
   output var logic  clock_halt_request_n = 1'b1,
   output var logic  mgmt_interrupt_n = 1'b1
);
   timeunit 1ns;
   timeprecision 100ps;

   // supplies come up, then one scaled init pulse
   task automatic power_up;
      @(negedge ref_clk);
      supplies_stable = 1'b1;
      repeat (INIT_CLKS) @(negedge ref_clk);
      hard_init_n = 1'b1;
   endtask : power_up

   // pin levels change off the sampling edge
   task automatic drive(input logic i, input logic h, input logic s, input logic m);
      @(negedge ref_clk);
      hard_init_n = i;
      clock_halt_request_n = h;
      sleep_request_n = s;
      mgmt_interrupt_n = m;
   endtask : drive
endmodule : crs_sys_model
`default_nettype wire

/* File: testbench/crs_ctrl_tb.sv */
`default_nettype none
module crs_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ------
   // signals
   // ------
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic bclk_present = 1'b1;
   logic core_bus_req = 1'b0;
   logic mgmt_exit = 1'b0;
   logic snoop_req = 1'b0;
   logic intr_req = 1'b0;
   logic hard_init_n, supplies_stable, sleep_request_n, clock_halt_request_n, mgmt_interrupt_n;
   logic [crs_pkg::CFG_W-1:0] cfg_pins, cfg_options, exp_cfg;
   logic bus_out_active, bus_out_oe_n, cache_invalidate, cache_writeback_en, cfg_valid;
   logic core_clk_en, bus_clk_en, apic_clk_en, pll_en, snoop_accept, intr_accept;
   logic state_save, mgmt_ack_txn, protected_handler_mode, handler_fetch, sleeping;
   logic [31:0] seed = 32'h1e67;
   logic [4:0] t_halt = 5'h10;
   logic [4:0] t_sleep = 5'h19;
   logic [4:0] t_mgmt = 5'h1b;
   int t_st[5] = '{2, 3, 3, 2, 1};
   int errors = 0;
   int n_tests = 0;
   int k;

   crs_sys_model #(.INIT_CLKS(40)) sys (.ref_clk, .hard_init_n, .supplies_stable,
      .sleep_request_n, .clock_halt_request_n, .mgmt_interrupt_n);
   crs_ctrl uut (.ref_clk, .rst, .hard_init_n, .supplies_stable, .sleep_request_n,
      .clock_halt_request_n, .mgmt_interrupt_n, .bclk_present, .cfg_pins, .core_bus_req,
      .snoop_req, .intr_req, .mgmt_exit, .bus_out_active, .bus_out_oe_n, .cache_invalidate,
      .cache_writeback_en, .cfg_options, .cfg_valid, .core_clk_en, .bus_clk_en, .apic_clk_en,
      .pll_en, .snoop_accept, .intr_accept, .state_save, .mgmt_ack_txn, .protected_handler_mode,
      .handler_fetch, .sleeping);

   // clock and random side requests
   always #12.5 ref_clk = ~ref_clk;
   always @(negedge ref_clk) begin
      seed = xs(seed);
      snoop_req = seed[0];
      intr_req = seed[1];
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic fail(input string m);
      errors++;
      $display("Error %0t: %s", $time, m);
   endtask : fail

   task automatic settle;
      repeat (5) @(negedge ref_clk);
      #1;
   endtask : settle

   // expected outputs per mode: 0 init, 1 run, 2 halt, 3 sleep, 4 handler
   task automatic chk(input int s);
      n_tests++;
      if (s == 0) begin
         if (cache_invalidate !== 1'b1 || cache_writeback_en !== 1'b0 || bus_out_active !== 1'b0)
            fail("init outputs");
      end else if (sleeping !== (s == 3) || protected_handler_mode !== (s == 4)
         || cache_invalidate !== 1'b0 || core_clk_en !== (s == 1 || s == 4)
         || bus_clk_en !== (s != 3) || apic_clk_en !== (s != 3) || pll_en !== 1'b1
         || state_save !== 1'b0 || mgmt_ack_txn !== 1'b0)
         fail("mode outputs");
      else if (s < 4 && (snoop_accept !== (snoop_req && s != 3)
         || intr_accept !== (intr_req && s != 3)))
         fail("request gating");
      else if (s == 4 && handler_fetch !== 1'b1)
         fail("handler fetch");
   endtask : chk

   task automatic stop_test;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   // hang guard
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail("timeout");
      stop_test();
   end

   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk) rst = 1'b0;
      exp_cfg = seed[15:8] | 8'h81;
      cfg_pins = exp_cfg;
      settle();
      chk(0);
      sys.power_up();
      settle();
      chk(1);
      n_tests++;
      if (cfg_options !== exp_cfg || cfg_valid !== 1'b1 || bus_out_oe_n !== 1'b0)
         fail("config latch");
      for (k = 0; k < 5; k++) begin
         sys.drive(1'b1, t_halt[k], t_sleep[k], t_mgmt[k]);
         settle();
         chk(t_st[k]);
      end
      sys.drive(1'b1, 1'b1, 1'b1, 1'b0);
      for (k = 0; k < 12 && mgmt_ack_txn !== 1'b1; k++)
         @(posedge ref_clk) #1;
      n_tests++;
      if (k == 12)
         fail("no acknowledge");
      settle();
      chk(4);
      mgmt_exit = 1'b1;
      sys.drive(1'b1, 1'b1, 1'b1, 1'b1);
      settle();
      chk(1);
      mgmt_exit = 1'b0;
      core_bus_req = 1'b1;
      settle();
      n_tests++;
      if (bus_out_active !== 1'b1)
         fail("bus not driven");
      sys.drive(1'b0, 1'b1, 1'b1, 1'b1);
      for (k = 0; k < 5 && bus_out_active !== 1'b0; k++)
         @(posedge ref_clk) #1;
      n_tests++;
      if (k > 3)
         fail("bus release late");
      core_bus_req = 1'b0;
      sys.drive(1'b0, 1'b1, 1'b1, 1'b0);
      settle();
      exp_cfg = ~exp_cfg;
      cfg_pins = exp_cfg;
      sys.drive(1'b1, 1'b1, 1'b1, 1'b0);
      settle();
      n_tests++;
      if (bus_out_oe_n !== 1'b1)
         fail("outputs not tristated");
      n_tests++;
      if (cfg_options !== exp_cfg || cfg_valid !== 1'b1)
         fail("config not relatched");
      sys.drive(1'b1, 1'b1, 1'b1, 1'b1);
      sys.drive(1'b0, 1'b1, 1'b1, 1'b1);
      settle();
      sys.drive(1'b1, 1'b1, 1'b1, 1'b1);
      settle();
      n_tests++;
      if (bus_out_oe_n !== 1'b0)
         fail("tristate kept after init");
      sys.drive(1'b1, 1'b0, 1'b0, 1'b1);
      settle();
      settle();
      chk(3);
      sys.drive(1'b0, 1'b0, 1'b0, 1'b1);
      settle();
      chk(0);
      sys.drive(1'b1, 1'b1, 1'b1, 1'b1);
      settle();
      chk(1);
      @(negedge ref_clk) bclk_present = 1'b0;
      settle();
      n_tests++;
      if (bus_clk_en !== 1'b0 || core_clk_en !== 1'b1)
         fail("bus clock loss not seen");
      bclk_present = 1'b1;
      settle();
      chk(1);
      @(negedge ref_clk) rst = 1'b1;
      @(negedge ref_clk) rst = 1'b0;
      #1;
      chk(0);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(0);
      stop_test();
   end
endmodule : crs_ctrl_tb
`default_nettype wire
